// File: hdl/wdh_top.sv
// Watchdog timer with halt entry and wake-up control
`timescale 1ns/1ps

module wdh_top #(
  parameter int PORT_W = 8,
  parameter int IRQ_W = 4,
  parameter int KEY_DELAY = wdh_pkg::KEY_RESET_DELAY_CYC
) (
  input wire logic sys_clk_in, // 40 MHz clock
  input wire logic rst_n_in, // Async power-on reset
  input wire logic clk_en_in, // Freezes all state but the reset synchroniser when low
  input wire logic sub_tick_in, // One pulse per sub clock period
  input wire logic halt_in, // Halt instruction pulse
  input wire logic clear_watchdog_instr_in, // Clear-watchdog instruction pulse
  input wire logic idle_select_in, // Idle rather than sleep
  input wire logic fast_mode_in, // Core wakes into fast mode
  input wire logic hs_osc_stable_in, // High speed oscillator ready
  input wire logic [PORT_W-1:0] porta_in, // Port A pin levels
  input wire logic [IRQ_W-1:0] irq_flag_in, // Interrupt request flags
  input wire logic [IRQ_W-1:0] irq_enable_in, // Interrupt enables
  input wire logic stack_full_in, // Stack full
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  output logic cpu_run_out, // Core may execute
  output logic sys_clk_en_out, // System clock gate
  output logic timebase_en_out, // Time base clock gate
  output logic full_reset_out, // Whole-device reset pulse
  output logic pc_sp_reset_out, // PC and SP reset pulse
  output logic irq_vector_out, // Take interrupt on wake
  output logic start_up_timer_out // Start-up wait active
);

  // ---------------------------------------------------------------
  // Reset synchroniser
  // ---------------------------------------------------------------
  // Assertion stays asynchronous, release passes two flops
  logic rst_meta, rst_n;
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic logic key_ok(input logic [4:0] k);
    key_ok = (k == wdh_pkg::KEY_ENABLE_A) || (k == wdh_pkg::KEY_ENABLE_B);
  endfunction

  function automatic logic [18:0] limit(input logic [2:0] s);
    case (s)
      3'h0: limit = 19'h00100;
      3'h1: limit = 19'h00400;
      3'h2: limit = 19'h01000;
      3'h3: limit = 19'h04000;
      3'h4: limit = 19'h08000;
      3'h5: limit = 19'h10000;
      3'h6: limit = 19'h20000;
      default: limit = 19'h40000;
    endcase
  endfunction

  // Address decode for the write error path
  function automatic logic mapped(input logic [11:0] a);
    if (a == wdh_pkg::ADDR_WDT_CONFIG) begin
      mapped = 1'b1;
    end else if (a == wdh_pkg::ADDR_SYS_CTRL) begin
      mapped = 1'b1;
    end else if (a == wdh_pkg::ADDR_STATUS) begin
      mapped = 1'b1;
    end else if (a == wdh_pkg::ADDR_WAKE_EN) begin
      mapped = 1'b1;
    end else if (a == wdh_pkg::ADDR_MODE) begin
      mapped = 1'b1;
    end else if (a == wdh_pkg::ADDR_CMD) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  endfunction

  // System clock runs while executing, in idle1 and during start-up
  function automatic logic sys_clock_on(input wdh_pkg::wdh_mode_t m);
    sys_clock_on = (m == wdh_pkg::WDH_RUN) || (m == wdh_pkg::WDH_IDLE1) || (m == wdh_pkg::WDH_START);
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0] wdt_config, next_wdt_config;
  logic idle_sysclk_keep, next_idle_sysclk_keep;
  logic wdt_key_reset_flag, next_wdt_key_reset_flag;
  logic power_down_flag, next_power_down_flag;
  logic wdt_timeout_flag, next_wdt_timeout_flag;
  logic [PORT_W-1:0] porta_wake_enable, next_porta_wake_enable;
  logic [PORT_W-1:0] porta_q, next_porta_q;
  logic [IRQ_W-1:0] irq_mask, next_irq_mask;
  logic [18:0] wdt_count, next_wdt_count;
  logic [15:0] key_delay, next_key_delay;
  logic key_bad, next_key_bad;
  wdh_pkg::wdh_mode_t mode, next_mode;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_cpu_run, next_sys_clk_en, next_tb_en;
  logic next_full_reset, next_pc_sp_reset, next_irq_vector, next_sst;

  logic wr, rd, sw_clr_cmd, sw_halt_cmd;
  logic wr_done, cmd_wr;
  logic [4:0] key;
  logic [2:0] sel;
  logic overflow, asleep, port_wake, irq_wake, do_halt, do_clr;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  // Writes land at the edge that completes the transfer
  assign wr_done = wr && pready;
  assign cmd_wr = wr_done && (paddr == wdh_pkg::ADDR_CMD);
  assign sw_halt_cmd = cmd_wr && pwdata[wdh_pkg::CMD_HALT_BIT];
  assign sw_clr_cmd = cmd_wr && pwdata[wdh_pkg::CMD_CLR_BIT];
  assign key = wdt_config[wdh_pkg::KEY_LSB +: 5];
  assign sel = wdt_config[wdh_pkg::SEL_LSB +: 3];
  assign asleep = (mode == wdh_pkg::WDH_SLEEP) || (mode == wdh_pkg::WDH_IDLE0) || (mode == wdh_pkg::WDH_IDLE1);
  assign overflow = sub_tick_in && (wdt_count == limit(sel) - 19'h00001);
  // Edge detector resets high, the idle pin level
  assign port_wake = asleep && |(porta_q & ~porta_in & porta_wake_enable);
  assign irq_wake = asleep && |(irq_flag_in & ~irq_mask);
  assign do_halt = (halt_in || sw_halt_cmd) && (mode == wdh_pkg::WDH_RUN);
  assign do_clr = clear_watchdog_instr_in || sw_clr_cmd;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    next_wdt_config = wdt_config;
    next_idle_sysclk_keep = idle_sysclk_keep;
    next_wdt_key_reset_flag = wdt_key_reset_flag;
    next_power_down_flag = power_down_flag;
    next_wdt_timeout_flag = wdt_timeout_flag;
    next_porta_wake_enable = porta_wake_enable;
    next_porta_q = porta_in;
    next_irq_mask = irq_mask;
    next_wdt_count = wdt_count;
    next_key_delay = key_delay;
    next_key_bad = key_bad;
    next_mode = mode;
    next_prdata = 32'h00000000;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_full_reset = 1'b0;
    next_pc_sp_reset = 1'b0;
    next_irq_vector = 1'b0;

    // Register writes
    if (wr_done) begin
      if (paddr == wdh_pkg::ADDR_WDT_CONFIG) begin
        next_wdt_config = pwdata[7:0];
      end else if (paddr == wdh_pkg::ADDR_SYS_CTRL) begin
        next_idle_sysclk_keep = pwdata[wdh_pkg::CTRL_KEEP_BIT];
        if (!pwdata[wdh_pkg::CTRL_KEYRST_BIT]) begin
          next_wdt_key_reset_flag = 1'b0;
        end
      end else if (paddr == wdh_pkg::ADDR_WAKE_EN) begin
        next_porta_wake_enable = pwdata[PORT_W-1:0];
      end
    end

    // Watchdog counter
    if (sub_tick_in) begin
      next_wdt_count = wdt_count + 19'h00001;
    end
    if (do_clr) begin
      next_wdt_count = 19'h00000;
      next_power_down_flag = 1'b0;
    end

    // Key check and delayed reset
    if (!key_ok(key)) begin
      if (!key_bad) begin
        next_key_bad = 1'b1;
        next_key_delay = 16'h0000;
        next_wdt_count = 19'h00000;
      end else if (sub_tick_in) begin
        next_key_delay = key_delay + 16'h0001;
      end
      if (key_bad && sub_tick_in && key_delay == 16'(KEY_DELAY - 1)) begin
        next_full_reset = 1'b1;
        next_wdt_key_reset_flag = 1'b1;
        next_wdt_config = wdh_pkg::WDT_CONFIG_RST;
        next_key_bad = 1'b0;
        next_wdt_count = 19'h00000;
        next_mode = wdh_pkg::WDH_RUN;
      end
    end else begin
      next_key_bad = 1'b0;
    end

    // Halt, wake and overflow
    case (mode)
      wdh_pkg::WDH_RUN: begin
        // Overflow wins over a halt in the same cycle
        if (overflow && key_ok(key)) begin
          next_full_reset = 1'b1;
          next_wdt_timeout_flag = 1'b1;
          next_wdt_count = 19'h00000;
        end else if (do_halt) begin
          next_power_down_flag = 1'b1;
          next_wdt_timeout_flag = 1'b0;
          next_wdt_count = 19'h00000;
          next_irq_mask = irq_flag_in;
          if (!idle_select_in) begin
            next_mode = wdh_pkg::WDH_SLEEP;
          end else if (idle_sysclk_keep) begin
            next_mode = wdh_pkg::WDH_IDLE1;
          end else begin
            next_mode = wdh_pkg::WDH_IDLE0;
          end
        end
      end
      wdh_pkg::WDH_SLEEP, wdh_pkg::WDH_IDLE0, wdh_pkg::WDH_IDLE1: begin
        if (overflow) begin
          next_wdt_timeout_flag = 1'b1;
          next_pc_sp_reset = 1'b1;
          next_wdt_count = 19'h00000;
        end
        if (overflow || port_wake || irq_wake) begin
          next_irq_vector = irq_wake && !overflow && |(irq_flag_in & ~irq_mask & irq_enable_in)
            && !stack_full_in;
          if (mode == wdh_pkg::WDH_SLEEP && fast_mode_in) begin
            next_mode = wdh_pkg::WDH_START;
          end else begin
            next_mode = wdh_pkg::WDH_RUN;
          end
        end
      end
      default: begin
        if (hs_osc_stable_in) begin
          next_mode = wdh_pkg::WDH_RUN;
        end
      end
    endcase

    // Register reads
    if (rd) begin
      if (paddr == wdh_pkg::ADDR_WDT_CONFIG) begin
        next_prdata = {24'h000000, wdt_config};
      end else if (paddr == wdh_pkg::ADDR_SYS_CTRL) begin
        next_prdata = {24'h000000, idle_sysclk_keep, 6'h00, wdt_key_reset_flag};
      end else if (paddr == wdh_pkg::ADDR_STATUS) begin
        next_prdata = {26'h0000000, hs_osc_stable_in, mode, wdt_timeout_flag, power_down_flag};
      end else if (paddr == wdh_pkg::ADDR_WAKE_EN) begin
        next_prdata = 32'(porta_wake_enable);
      end else if (paddr == wdh_pkg::ADDR_MODE || paddr == wdh_pkg::ADDR_CMD) begin
        next_prdata = 32'h00000000;
      end else begin
        next_pslverr = 1'b1;
      end
    end
    if (wr && !pready && !mapped(paddr)) begin
      next_pslverr = 1'b1;
    end
    if (psel && penable && !pready) begin
      next_pready = 1'b1;
      next_pslverr = pslverr || next_pslverr;
      if (!pwrite) begin
        next_prdata = prdata;
        next_pslverr = pslverr;
      end
    end

    // Clock and core gating outputs
    next_cpu_run = (next_mode == wdh_pkg::WDH_RUN);
    next_sys_clk_en = sys_clock_on(next_mode);
    next_tb_en = (next_mode != wdh_pkg::WDH_SLEEP);
    next_sst = (next_mode == wdh_pkg::WDH_START);
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wdt_config <= wdh_pkg::WDT_CONFIG_RST;
      idle_sysclk_keep <= 1'b0;
      wdt_key_reset_flag <= 1'b0;
      power_down_flag <= 1'b0;
      wdt_timeout_flag <= 1'b0;
      porta_wake_enable <= '0;
      porta_q <= '1;
      irq_mask <= '0;
      wdt_count <= 19'h00000;
      key_delay <= 16'h0000;
      key_bad <= 1'b0;
      mode <= wdh_pkg::WDH_RUN;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      cpu_run_out <= 1'b1;
      sys_clk_en_out <= 1'b1;
      timebase_en_out <= 1'b1;
      full_reset_out <= 1'b0;
      pc_sp_reset_out <= 1'b0;
      irq_vector_out <= 1'b0;
      start_up_timer_out <= 1'b0;
    end else if (clk_en_in) begin
      wdt_config <= next_wdt_config;
      idle_sysclk_keep <= next_idle_sysclk_keep;
      wdt_key_reset_flag <= next_wdt_key_reset_flag;
      power_down_flag <= next_power_down_flag;
      wdt_timeout_flag <= next_wdt_timeout_flag;
      porta_wake_enable <= next_porta_wake_enable;
      porta_q <= next_porta_q;
      irq_mask <= next_irq_mask;
      wdt_count <= next_wdt_count;
      key_delay <= next_key_delay;
      key_bad <= next_key_bad;
      mode <= next_mode;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      cpu_run_out <= next_cpu_run;
      sys_clk_en_out <= next_sys_clk_en;
      timebase_en_out <= next_tb_en;
      full_reset_out <= next_full_reset;
      pc_sp_reset_out <= next_pc_sp_reset;
      irq_vector_out <= next_irq_vector;
      start_up_timer_out <= next_sst;
    end
  end

endmodule // wdh_top

// File: shared/wdh_pkg.sv
// Package of constants and types for the watchdog, halt and wake-up block
package wdh_pkg;

  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [11:0] ADDR_WDT_CONFIG = 12'h000;
  localparam logic [11:0] ADDR_SYS_CTRL = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_WAKE_EN = 12'h00C;
  localparam logic [11:0] ADDR_MODE = 12'h010;
  localparam logic [11:0] ADDR_CMD = 12'h014;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int KEY_LSB = 3;
  localparam int SEL_LSB = 0;
  localparam int CTRL_KEEP_BIT = 7;
  localparam int CTRL_KEYRST_BIT = 0;
  localparam int ST_PDF_BIT = 0;
  localparam int ST_TO_BIT = 1;
  localparam int ST_MODE_LSB = 2;
  localparam int ST_HS_BIT = 5;
  localparam int MODE_IDLE_BIT = 0;
  localparam int CMD_HALT_BIT = 0;
  localparam int CMD_CLR_BIT = 1;

  // ---------------------------------------------------------------
  // Reset values and key codes
  // ---------------------------------------------------------------
  localparam logic [7:0] WDT_CONFIG_RST = 8'h53;
  localparam logic [4:0] KEY_ENABLE_A = 5'h0A;
  localparam logic [4:0] KEY_ENABLE_B = 5'h15;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int KEY_RESET_DELAY_CYC = 16;

  typedef enum logic [2:0] {
    WDH_RUN,
    WDH_SLEEP,
    WDH_IDLE0,
    WDH_IDLE1,
    WDH_START
  } wdh_mode_t;

endpackage

// File: verif/wdh_core_model.sv
// Core side model: sub clock ticks and instruction pulses
`timescale 1ns/1ps
module wdh_core_model (
  input wire logic clk_in, // System clock
  input wire logic rst_n_in, // Async reset, active low
  output logic sub_tick_out, // Tick every second cycle
  output logic halt_out, // Halt instruction pulse
  output logic clear_watchdog_instr_out // Clear instruction pulse
);
  // ---------------------------------------------------------------
  // Free running sub clock and instruction tasks
  // ---------------------------------------------------------------
  logic next_sub_tick;
  always_comb begin
    next_sub_tick = !sub_tick_out;
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sub_tick_out <= 1'h0;
    end else begin
      sub_tick_out <= next_sub_tick;
    end
  end
  initial begin
    halt_out = 1'h0;
    clear_watchdog_instr_out = 1'h0;
  end
  task automatic halt_op();
    @(posedge clk_in);
    halt_out <= 1'h1;
    @(posedge clk_in);
    halt_out <= 1'h0;
  endtask
  // Software clear before overflow
  task automatic clear_op();
    @(posedge clk_in);
    clear_watchdog_instr_out <= 1'h1;
    @(posedge clk_in);
    clear_watchdog_instr_out <= 1'h0;
  endtask
endmodule // wdh_core_model

// File: verif/wdh_top_assertions.sv
// Concurrent checks on the watchdog, halt and wake-up ports
`timescale 1ns/1ps
module wdh_checker #(
  parameter int PORT_W = 8,
  parameter int IRQ_W = 4
) (
  input wire logic sys_clk_in, rst_n_in, clk_en_in, sub_tick_in, halt_in, clear_watchdog_instr_in, // Core
  input wire logic idle_select_in, fast_mode_in, hs_osc_stable_in, stack_full_in, // Mode
  input wire logic [PORT_W-1:0] porta_in, // Port A
  input wire logic [IRQ_W-1:0] irq_flag_in, irq_enable_in, // Interrupts
  input wire logic psel, penable, pwrite, // APB control
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] pwdata, prdata, // APB data
  input wire logic pready, pslverr, cpu_run_out, sys_clk_en_out, timebase_en_out, // Status
  input wire logic full_reset_out, pc_sp_reset_out, irq_vector_out, start_up_timer_out // Events
);
  // ---------------------------------------------------------------
  // Sequences and assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence apb_access;
    psel && penable;
  endsequence
  sequence halt_taken;
    halt_in && cpu_run_out;
  endsequence
  a_halt_stops_cpu: assert property (halt_taken |-> ##[1:3] !cpu_run_out)
    else $error("halt did not stop the core");
  a_sleep_gates_clk: assert property (halt_taken ##0 !idle_select_in |->
    ##[1:3] !sys_clk_en_out && !timebase_en_out)
    else $error("sleep left a clock running");
  a_idle_timebase_on: assert property (halt_taken ##0 idle_select_in |-> ##1 timebase_en_out [*3])
    else $error("idle stopped the time base");
  a_apb_one_wait: assert property (apb_setup ##1 apb_access |-> !pready ##1 pready)
    else $error("apb wait state wrong");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_unmapped_err: assert property (pready |-> pslverr == (paddr > 12'h014))
    else $error("slave error on wrong address");
  a_sleep_ovf_partial: assert property (pc_sp_reset_out |-> !$past(cpu_run_out) && !full_reset_out)
    else $error("sleep overflow gave a full reset");
  a_clear_holds_off: assert property (clear_watchdog_instr_in |-> ##2 !full_reset_out [*8])
    else $error("overflow right after clear");
  a_fast_wake_gate: assert property ($rose(cpu_run_out) && fast_mode_in |-> $past(hs_osc_stable_in))
    else $error("core ran before oscillator stable");
endmodule // wdh_checker

bind wdh_top wdh_checker #(.PORT_W(PORT_W), .IRQ_W(IRQ_W)) u_chk (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
  .clk_en_in(clk_en_in), .sub_tick_in(sub_tick_in), .halt_in(halt_in), .clear_watchdog_instr_in(clear_watchdog_instr_in),
  .idle_select_in(idle_select_in), .fast_mode_in(fast_mode_in), .hs_osc_stable_in(hs_osc_stable_in),
  .stack_full_in(stack_full_in), .porta_in(porta_in), .irq_flag_in(irq_flag_in), .irq_enable_in(irq_enable_in),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cpu_run_out(cpu_run_out), .sys_clk_en_out(sys_clk_en_out),
  .timebase_en_out(timebase_en_out), .full_reset_out(full_reset_out), .pc_sp_reset_out(pc_sp_reset_out),
  .irq_vector_out(irq_vector_out), .start_up_timer_out(start_up_timer_out));

// File: verif/wdh_top_tb.sv
// Self-checking bench for the watchdog, halt and wake-up block
`timescale 1ns/1ps
module wdh_top_tb;
  logic sys_clk_in = 1'h0;
  logic rst_n_in = 1'h0;
  logic clk_en_in = 1'h1;
  logic idle_select_in = 1'h0;
  logic fast_mode_in = 1'h0;
  logic hs_osc_stable_in = 1'h1;
  logic stack_full_in = 1'h0;
  logic [7:0] porta_in = 8'hFF;
  logic [3:0] irq_flag_in = 4'h0;
  logic [3:0] irq_enable_in = 4'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, cpu_run_out, sys_clk_en_out, timebase_en_out, err;
  logic full_reset_out, pc_sp_reset_out, irq_vector_out, start_up_timer_out, sub_tick, halt_p, clr_p;
  logic [3:0] evt;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  int rst_seen = 0;
  int vec_seen = 0;
  int n;
  // ---------------------------------------------------------------
  // Clock, instances, event counters
  // ---------------------------------------------------------------
  always #12.5 sys_clk_in = !sys_clk_in;
  assign evt = {irq_vector_out, pc_sp_reset_out, cpu_run_out, full_reset_out};
  wdh_core_model core (.clk_in(sys_clk_in), .rst_n_in(rst_n_in), .sub_tick_out(sub_tick), .halt_out(halt_p),
    .clear_watchdog_instr_out(clr_p));
  wdh_top dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in), .sub_tick_in(sub_tick),
    .halt_in(halt_p), .clear_watchdog_instr_in(clr_p), .idle_select_in(idle_select_in), .fast_mode_in(fast_mode_in),
    .hs_osc_stable_in(hs_osc_stable_in), .porta_in(porta_in), .irq_flag_in(irq_flag_in),
    .irq_enable_in(irq_enable_in), .stack_full_in(stack_full_in), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_run_out(cpu_run_out), .sys_clk_en_out(sys_clk_en_out), .timebase_en_out(timebase_en_out),
    .full_reset_out(full_reset_out), .pc_sp_reset_out(pc_sp_reset_out), .irq_vector_out(irq_vector_out),
    .start_up_timer_out(start_up_timer_out));
  always @(posedge sys_clk_in) begin
    cycles++;
    if (full_reset_out === 1'h1) rst_seen++;
    if (irq_vector_out === 1'h1) vec_seen++;
    if (cycles == 20000) begin
      mismatches++;
      final_report();
    end
  end
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk_in);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_in);
    penable <= 1'h1;
    do begin
      @(posedge sys_clk_in);
      k++;
    end while (pready !== 1'h1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1) chk("pready", 32'h1, 32'h0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m, input string what);
    apb(1'h0, a, 32'h0);
    chk(what, exp, rdat & m);
  endtask
  task automatic wait_evt(input int b, input int lim);
    n = 0;
    while (evt[b] !== 1'h1 && n < lim) begin
      @(posedge sys_clk_in);
      n++;
    end
  endtask
  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge sys_clk_in);
    rst_n_in <= 1'h1;
    repeat (3) @(posedge sys_clk_in);
    rd(wdh_pkg::ADDR_WDT_CONFIG, 32'h53, 32'hFF, "config reset");
    rd(wdh_pkg::ADDR_SYS_CTRL, 32'h0, 32'hFFFFFFFF, "ctrl reset");
    rd(wdh_pkg::ADDR_STATUS, 32'h0, 32'h1F, "status reset");
    apb(1'h0, 12'h040, 32'h0);
    chk("unmapped error", 32'h1, err);
    $display("test reset_values done");
    for (int i = 0; i < 2; i++) begin
      wr(wdh_pkg::ADDR_WDT_CONFIG, (i == 0) ? 32'h50 : 32'hA9);
      core.clear_op();
      wait_evt(0, 4000);
      chk("overflow time", 32'h1, n >= (2 << (8 + 2 * i)) - 6 && n <= (2 << (8 + 2 * i)) + 6);
      rd(wdh_pkg::ADDR_STATUS, 32'h2, 32'h3, "timeout flag");
    end
    wr(wdh_pkg::ADDR_WDT_CONFIG, 32'h50);
    rst_seen = 0;
    repeat (4) begin
      repeat (400) @(posedge sys_clk_in);
      core.clear_op();
    end
    chk("cleared in time", 32'h0, rst_seen);
    $display("test overflow done");
    wr(wdh_pkg::ADDR_WDT_CONFIG, 32'h57);
    wr(wdh_pkg::ADDR_WAKE_EN, 32'h04);
    fast_mode_in <= 1'h1;
    hs_osc_stable_in <= 1'h0;
    core.halt_op();
    repeat (4) @(posedge sys_clk_in);
    chk("sleep gates", 32'h0, {cpu_run_out, sys_clk_en_out, timebase_en_out});
    rd(wdh_pkg::ADDR_STATUS, 32'h05, 32'h1F, "sleep status");
    porta_in <= 8'hF7;
    repeat (10) @(posedge sys_clk_in);
    chk("masked pin", 32'h0, cpu_run_out);
    porta_in <= 8'hF3;
    repeat (20) @(posedge sys_clk_in);
    chk("oscillator wait", 32'h1, {cpu_run_out, start_up_timer_out});
    hs_osc_stable_in <= 1'h1;
    wait_evt(1, 20);
    chk("pin wake", 32'h1, cpu_run_out);
    porta_in <= 8'hFF;
    fast_mode_in <= 1'h0;
    $display("test sleep_wake done");
    wr(wdh_pkg::ADDR_SYS_CTRL, 32'h80);
    idle_select_in <= 1'h1;
    irq_enable_in <= 4'h1;
    core.halt_op();
    repeat (4) @(posedge sys_clk_in);
    chk("idle1 clocks", 32'h3, {cpu_run_out, sys_clk_en_out, timebase_en_out});
    rd(wdh_pkg::ADDR_STATUS, 32'h0D, 32'h1F, "idle1 status");
    irq_flag_in <= 4'h1;
    wait_evt(3, 20);
    chk("irq vector", 32'h1, irq_vector_out);
    irq_flag_in <= 4'h0;
    wait_evt(1, 20);
    wr(wdh_pkg::ADDR_SYS_CTRL, 32'h0);
    irq_enable_in <= 4'h0;
    irq_flag_in <= 4'h2;
    core.halt_op();
    repeat (20) @(posedge sys_clk_in);
    chk("preset flag", 32'h1, {cpu_run_out, sys_clk_en_out, timebase_en_out});
    vec_seen = 0;
    irq_flag_in <= 4'h3;
    wait_evt(1, 20);
    chk("disabled irq wake", 32'h1, cpu_run_out);
    repeat (4) @(posedge sys_clk_in);
    chk("no vector", 32'h0, vec_seen);
    irq_flag_in <= 4'h0;
    core.clear_op();
    rd(wdh_pkg::ADDR_STATUS, 32'h0, 32'h1, "power down cleared");
    $display("test idle_irq done");
    wr(wdh_pkg::ADDR_WDT_CONFIG, 32'h50);
    idle_select_in <= 1'h0;
    rst_seen = 0;
    core.halt_op();
    repeat (2) @(posedge sys_clk_in);
    wait_evt(2, 700);
    chk("sleep overflow", 32'h1, pc_sp_reset_out);
    rd(wdh_pkg::ADDR_STATUS, 32'h3, 32'h3, "sleep flags");
    chk("no full reset", 32'h0, rst_seen);
    wr(wdh_pkg::ADDR_WDT_CONFIG, 32'h03);
    clk_en_in <= 1'h0;
    rst_seen = 0;
    repeat (100) @(posedge sys_clk_in);
    chk("frozen key delay", 32'h0, rst_seen);
    clk_en_in <= 1'h1;
    wait_evt(0, 200);
    chk("key delay", 32'h1, n >= 24 && n <= 40);
    wr(wdh_pkg::ADDR_WDT_CONFIG, 32'h57);
    rd(wdh_pkg::ADDR_SYS_CTRL, 32'h1, 32'h1, "key flag set");
    wr(wdh_pkg::ADDR_SYS_CTRL, 32'h0);
    rd(wdh_pkg::ADDR_SYS_CTRL, 32'h0, 32'h1, "key flag clear");
    wr(wdh_pkg::ADDR_SYS_CTRL, 32'h1);
    rd(wdh_pkg::ADDR_SYS_CTRL, 32'h0, 32'h1, "key flag not set");
    $display("test resets done");
    final_report();
  end
endmodule // wdh_top_tb
